// >>> rtl/fnpll_ctrl.sv
// fractional-n pll control: apb registers, mash modulator, triangular spread
// assumes clk is the detector clock and all inputs are synchronous to it
//
// Summary of operation
// - detector rate is reference over divider, twice reference at zero
// - divider zero selects the reference doubler
// - feedback integer from 15-bit field
// - numerator is upper 8 and lower 16 bits
// - denominator likewise, zero means two to 24
// - feedback divides oscillator by integer plus fraction
// - order 0 integer, 1..3 cascaded fractional order
// - live lock in status bit and pin
// - sticky bit records any loss of lock
// - spread disabled means no modulation at all
// - spread type 0 down, 1 centre
// - profile codes 0..3 legal, 4..7 forbidden
// - triangular deviation via fractional ratio modulation
// - presets give 31.5 khz modulation rate
// - modulation only on synthesizer clocks, not bypass
//
// The APB slave port and the placing of the registers are this design's own decisions.
module fnpll_ctrl
    import fnpll_pkg::*;
#(
    parameter int DIVW = 18
) (
    input  wire logic           clk,
    input  wire logic           arst_n,
    input  wire fnpll_apb_req_t apb_req,
    output fnpll_apb_rsp_t      apb_rsp,
    input  wire logic           lock_raw,
    output logic                lock_pin,
    output logic                ref_doubler_en,
    output logic [7:0]          reference_divide_value,
    output logic [DIVW-1:0]     fb_div,
    output logic                se_pfd,
    output logic [2:0]          lock_win,
    output logic                mod_active
);

    typedef struct packed {
        fnpll_cfg_t     cfg;
        fnpll_apb_rsp_t rsp;
        logic           live;
        logic           sticky;
        logic           bad_sel;
        logic [24:0]    acc1;
        logic [24:0]    acc2;
        logic [24:0]    acc3;
        logic           c2_d;
        logic [1:0]     c3_d;
        logic           c3_dd;
        fnpll_tri_t     tri_st;
        logic [10:0]    tcnt;
        logic [24:0]    offs;
        logic [DIVW-1:0] div;
        logic           dbl;
        logic           mact;
    } fnpll_state_t;

    fnpll_state_t st_r;
    fnpll_state_t st_nxt;

    function automatic logic [24:0] den_eff(input logic [23:0] d);
        den_eff = (d == 24'h000000) ? DEN_ZERO_AS : {1'b0, d};
    endfunction

    // one modulus stage: returns carry and new remainder
    function automatic logic [25:0] mod_step(input logic [24:0] acc, input logic [24:0] add,
                                              input logic [24:0] den);
        logic [25:0] s;
        s = {1'b0, acc} + {1'b0, add};
        if (s >= {1'b0, den}) begin
            mod_step = {1'b1, 25'(s - {1'b0, den})};
        end else begin
            mod_step = {1'b0, s[24:0]};
        end
    endfunction

    // peak deviation in numerator units for the chosen profile
    function automatic logic [24:0] peak_dev(input logic [2:0] sel, input logic [24:0] den,
                                             input logic [14:0] n);
        logic [63:0] full;
        logic [63:0] ppm;
        full = 64'(({39'h0, den} * {49'h0, n}) + {39'h0, den});
        ppm  = sel[0] ? 64'(DEPTH_H_PPM) : 64'(DEPTH_Q_PPM);
        peak_dev = 25'((full * ppm) / 64'(PPM_DIV));
    endfunction

    logic [24:0] den_w;
    logic [25:0] s1;
    logic [25:0] s2;
    logic [25:0] s3;
    logic [24:0] pk;
    logic [10:0] half_w;
    logic [24:0] base_w;
    logic [24:0] frac_w;
    logic signed [DIVW+1:0] shaped;
    logic        rd_ok;
    logic        wr_ok;
    logic [31:0] rdat;

    always_comb begin
        st_nxt  = st_r;
        den_w   = den_eff(st_r.cfg.den);
        pk      = peak_dev(st_r.cfg.ssc_sel, den_w, st_r.cfg.n_int);
        half_w  = st_r.cfg.ssc_sel[1] ? 11'(HALF50) : 11'(HALF25);
        rd_ok   = 1'b0;
        wr_ok   = 1'b0;
        rdat    = 32'h00000000;

        // apb slave, one wait state: answer in the access cycle after penable
        st_nxt.rsp.pready  = 1'b0;
        st_nxt.rsp.pslverr = 1'b0;
        if (apb_req.psel && apb_req.penable && !st_r.rsp.pready) begin
            st_nxt.rsp.pready = 1'b1;
            unique case (apb_req.paddr)
                OFS_REFDIV: begin
                    rdat = {24'h0, st_r.cfg.ref_div};
                    rd_ok = 1'b1;
                end
                OFS_NINT: begin
                    rdat = {17'h0, st_r.cfg.n_int};
                    rd_ok = 1'b1;
                end
                OFS_NUM: begin
                    rdat = {8'h0, st_r.cfg.num};
                    rd_ok = 1'b1;
                end
                OFS_DEN: begin
                    rdat = {8'h0, st_r.cfg.den};
                    rd_ok = 1'b1;
                end
                OFS_MODE: begin
                    rdat[MODE_ORDER_LO +: 2] = st_r.cfg.order;
                    rdat[MODE_SEPFD]         = st_r.cfg.se_pfd;
                    rdat[MODE_FRAC]          = st_r.cfg.frac_en;
                    rd_ok = 1'b1;
                end
                OFS_SSC: begin
                    rdat[SSC_EN_BIT]        = st_r.cfg.ssc_en;
                    rdat[SSC_TYPE_BIT]      = st_r.cfg.ssc_type;
                    rdat[SSC_SEL_LO +: 3]   = st_r.cfg.ssc_sel;
                    rd_ok = 1'b1;
                end
                OFS_LOCKWIN: begin
                    rdat = {29'h0, st_r.cfg.lock_win};
                    rd_ok = 1'b1;
                end
                OFS_STATUS: begin
                    rdat[ST_LIVE]   = st_r.live;
                    rdat[ST_STICKY] = st_r.sticky;
                    rdat[ST_BADSEL] = st_r.bad_sel;
                    rd_ok = 1'b1;
                end
                OFS_DIVOUT: begin
                    rdat = 32'(st_r.div);
                    rd_ok = 1'b1;
                end
                default: rd_ok = 1'b0;
            endcase
            wr_ok = rd_ok && apb_req.pwrite && (apb_req.paddr != OFS_DIVOUT);
            st_nxt.rsp.pslverr = !rd_ok;
            st_nxt.rsp.prdata  = apb_req.pwrite ? 32'h00000000 : rdat;
        end

        // configuration writes
        if (wr_ok) begin
            unique case (apb_req.paddr)
                OFS_REFDIV: st_nxt.cfg.ref_div = apb_req.pwdata[7:0];
                OFS_NINT:   st_nxt.cfg.n_int = apb_req.pwdata[14:0];
                OFS_NUM:    st_nxt.cfg.num = apb_req.pwdata[23:0];
                OFS_DEN:    st_nxt.cfg.den = apb_req.pwdata[23:0];
                OFS_MODE: begin
                    st_nxt.cfg.order   = apb_req.pwdata[MODE_ORDER_LO +: 2];
                    st_nxt.cfg.se_pfd  = apb_req.pwdata[MODE_SEPFD];
                    st_nxt.cfg.frac_en = apb_req.pwdata[MODE_FRAC];
                end
                OFS_SSC: begin
                    st_nxt.cfg.ssc_en   = apb_req.pwdata[SSC_EN_BIT];
                    st_nxt.cfg.ssc_type = apb_req.pwdata[SSC_TYPE_BIT];
                    st_nxt.cfg.ssc_sel  = apb_req.pwdata[SSC_SEL_LO +: 3];
                end
                OFS_LOCKWIN: st_nxt.cfg.lock_win = apb_req.pwdata[2:0];
                default: st_nxt.cfg = st_r.cfg;
            endcase
        end

        // lock indicators; a loss in the clearing cycle keeps the bit set
        st_nxt.live = lock_raw;
        if (wr_ok && apb_req.paddr == OFS_STATUS && apb_req.pwdata[ST_STICKY]) begin
            st_nxt.sticky = 1'b0;
        end
        if (!lock_raw) begin
            st_nxt.sticky = 1'b1;
        end

        // forbidden profile codes stop modulation and flag the condition
        st_nxt.bad_sel = st_r.cfg.ssc_en && (st_r.cfg.ssc_sel > SSC_MAX_SEL);
        st_nxt.mact    = st_r.cfg.ssc_en && !st_nxt.bad_sel && (st_r.cfg.order != ORD_INT);

        // triangle generator, offset in numerator units
        if (!st_nxt.mact) begin
            st_nxt.tri_st = FNPLL_IDLE;
            st_nxt.tcnt   = 11'h000;
            st_nxt.offs   = 25'h0;
        end else begin
            unique case (st_r.tri_st)
                FNPLL_IDLE: begin
                    st_nxt.tri_st = FNPLL_RISE;
                    st_nxt.tcnt   = 11'h000;
                end
                FNPLL_RISE: begin
                    st_nxt.tcnt = st_r.tcnt + 11'h001;
                    if (st_nxt.tcnt >= half_w) begin
                        st_nxt.tri_st = FNPLL_FALL;
                        st_nxt.tcnt   = 11'h000;
                    end
                end
                FNPLL_FALL: begin
                    st_nxt.tcnt = st_r.tcnt + 11'h001;
                    if (st_nxt.tcnt >= half_w) begin
                        st_nxt.tri_st = FNPLL_RISE;
                        st_nxt.tcnt   = 11'h000;
                    end
                end
            endcase
            st_nxt.offs = 25'((50'(pk) * 50'(st_r.tri_st == FNPLL_RISE ? st_r.tcnt : 11'(half_w - st_r.tcnt)))
                              / 50'(half_w));
        end

        // modulated fraction; centre spread swings about the nominal point
        base_w = {1'b0, st_r.cfg.num};
        if (!st_r.mact) begin
            frac_w = base_w;
        end else if (st_r.cfg.ssc_type) begin
            frac_w = 25'(base_w + (pk >> 1) - st_r.offs);
        end else begin
            frac_w = 25'(base_w - st_r.offs);
        end
        // fraction may step outside one modulus; keep it inside
        if (frac_w >= den_w) begin
            frac_w = 25'(den_w - 25'h1);
        end

        // cascaded modulus stages, one update per detector cycle
        s1 = mod_step(st_r.acc1, frac_w, den_w);
        s2 = mod_step(st_r.acc2, s1[24:0], den_w);
        s3 = mod_step(st_r.acc3, s2[24:0], den_w);
        shaped = '0;
        unique case (st_r.cfg.order)
            ORD_INT: shaped = '0;
            ORD_1:   shaped = (DIVW+2)'(s1[25]);
            ORD_2:   shaped = (DIVW+2)'(s1[25]) + (DIVW+2)'(s2[25]) - (DIVW+2)'(st_r.c2_d);
            ORD_3:   shaped = (DIVW+2)'(s1[25]) + (DIVW+2)'(s2[25]) - (DIVW+2)'(st_r.c2_d)
                              + (DIVW+2)'(s3[25]) - (DIVW+2)'($signed({1'b0, st_r.c3_d}))
                              + (DIVW+2)'(st_r.c3_dd);
        endcase
        if (st_r.cfg.order == ORD_INT) begin
            st_nxt.acc1 = 25'h0;
            st_nxt.acc2 = 25'h0;
            st_nxt.acc3 = 25'h0;
            st_nxt.c2_d = 1'b0;
            st_nxt.c3_d = 2'h0;
            st_nxt.c3_dd = 1'b0;
        end else begin
            st_nxt.acc1  = s1[24:0];
            st_nxt.acc2  = s2[24:0];
            st_nxt.acc3  = s3[24:0];
            st_nxt.c2_d  = s2[25];
            st_nxt.c3_d  = {1'b0, s3[25]} + {1'b0, st_r.c3_dd};
            st_nxt.c3_dd = s3[25];
        end
        st_nxt.div = DIVW'($signed({5'h0, st_r.cfg.n_int}) + shaped);

        st_nxt.dbl = (st_r.cfg.ref_div == 8'h00);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '{
                cfg: '{ref_div: RST_REFDIV, n_int: RST_NINT, num: RST_NUM, den: RST_DEN,
                       order: ORD_INT, se_pfd: 1'b1, frac_en: 1'b0, ssc_en: 1'b0,
                       ssc_type: 1'b0, ssc_sel: 3'h0, lock_win: RST_WIN},
                rsp: '0, live: 1'b0, sticky: 1'b0, bad_sel: 1'b0,
                acc1: 25'h0, acc2: 25'h0, acc3: 25'h0, c2_d: 1'b0, c3_d: 2'h0, c3_dd: 1'b0,
                tri_st: FNPLL_IDLE, tcnt: 11'h000, offs: 25'h0,
                div: DIVW'(RST_NINT), dbl: 1'b0, mact: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // bypass paths are outside this block and never see the modulation
    assign apb_rsp                = st_r.rsp;
    assign lock_pin               = st_r.live;
    assign ref_doubler_en         = st_r.dbl;
    assign reference_divide_value = st_r.cfg.ref_div;
    assign fb_div                 = st_r.div;
    assign se_pfd                 = st_r.cfg.se_pfd;
    assign lock_win               = st_r.cfg.lock_win;
    assign mod_active             = st_r.mact;

endmodule // fnpll_ctrl

// >>> rtl/fnpll_pkg.sv
// package for the fractional-n pll control block
// assumes a single clock domain and an apb register port
package fnpll_pkg;
    localparam int APB_AW = 8;
    // register byte offsets
    localparam logic [7:0] OFS_REFDIV   = 8'h00;
    localparam logic [7:0] OFS_NINT     = 8'h04;
    localparam logic [7:0] OFS_NUM      = 8'h08;
    localparam logic [7:0] OFS_DEN      = 8'h0c;
    localparam logic [7:0] OFS_MODE     = 8'h10;
    localparam logic [7:0] OFS_SSC      = 8'h14;
    localparam logic [7:0] OFS_LOCKWIN  = 8'h18;
    localparam logic [7:0] OFS_STATUS   = 8'h1c;
    localparam logic [7:0] OFS_DIVOUT   = 8'h20;
    // field positions
    localparam int MODE_ORDER_LO = 0;
    localparam int MODE_SEPFD    = 6;
    localparam int MODE_FRAC     = 10;
    localparam int SSC_EN_BIT    = 15;
    localparam int SSC_TYPE_BIT  = 5;
    localparam int SSC_SEL_LO    = 1;
    localparam int ST_LIVE       = 0;
    localparam int ST_STICKY     = 1;
    localparam int ST_BADSEL     = 2;
    // reset values, wide lock window code, modulus used for a zero denominator
    localparam logic [7:0]  RST_REFDIV = 8'h01;
    localparam logic [14:0] RST_NINT   = 15'h0060;
    localparam logic [23:0] RST_NUM    = 24'h000000;
    localparam logic [23:0] RST_DEN    = 24'h000000;
    localparam logic [2:0]  RST_WIN    = 3'h0;
    localparam logic [2:0]  WIN_WIDE   = 3'h7;
    localparam logic [24:0] DEN_ZERO_AS = 25'h1000000;
    // modulator orders
    localparam logic [1:0] ORD_INT = 2'h0;
    localparam logic [1:0] ORD_1   = 2'h1;
    localparam logic [1:0] ORD_2   = 2'h2;
    localparam logic [1:0] ORD_3   = 2'h3;
    // spread profile codes, 4..7 forbidden
    localparam logic [2:0] SSC_MAX_SEL = 3'h3;
    // modulation timing: 31.5 khz triangle, half period in detector cycles
    localparam int FMOD_HZ     = 31500;
    localparam int PFD25_HZ    = 25000000;
    localparam int PFD50_HZ    = 50000000;
    localparam int HALF25      = PFD25_HZ / (2 * FMOD_HZ);
    localparam int HALF50      = PFD50_HZ / (2 * FMOD_HZ);
    // spread depth in ppm
    localparam int DEPTH_Q_PPM = 2500;
    localparam int DEPTH_H_PPM = 5000;
    localparam int PPM_DIV     = 1000000;

    typedef enum logic [2:0] {
        FNPLL_RISE = 3'b001,
        FNPLL_FALL = 3'b010,
        FNPLL_IDLE = 3'b100
    } fnpll_tri_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } fnpll_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } fnpll_apb_rsp_t;

    typedef struct packed {
        logic [7:0]  ref_div;
        logic [14:0] n_int;
        logic [23:0] num;
        logic [23:0] den;
        logic [1:0]  order;
        logic        se_pfd;
        logic        frac_en;
        logic        ssc_en;
        logic        ssc_type;
        logic [2:0]  ssc_sel;
        logic [2:0]  lock_win;
    } fnpll_cfg_t;
endpackage

// >>> dv/fnpll_lock_src.sv
// stand-in for the analog lock detector of the loop
// assumes drop is driven by the bench right after a rising edge
module fnpll_lock_src #(
    parameter int SETTLE = 20
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic drop,
    output logic      lock_raw
);
    int cnt;
    // loop needs SETTLE cycles to lock; drop forces a brief loss
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 0;
            lock_raw <= 1'b0;
        end else begin
            if (cnt < SETTLE) cnt <= cnt + 1;
            lock_raw <= (cnt >= SETTLE) && !drop;
        end
    end
endmodule // fnpll_lock_src

// >>> dv/fnpll_ctrl_props.sv
// port checker for the pll control block
// assumes one clock domain; bound onto fnpll_ctrl below
module fnpll_ctrl_props
    import fnpll_pkg::*;
#(
    parameter int DIVW = 18
) (
    input wire logic            clk,
    input wire logic            arst_n,
    input wire fnpll_apb_req_t  apb_req,
    input wire fnpll_apb_rsp_t  apb_rsp,
    input wire logic            lock_raw,
    input wire logic            lock_pin,
    input wire logic            ref_doubler_en,
    input wire logic [7:0]      reference_divide_value,
    input wire logic [DIVW-1:0] fb_div,
    input wire logic            se_pfd,
    input wire logic [2:0]      lock_win,
    input wire logic            mod_active
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    logic        done_w;
    logic        done_r;
    logic [7:0]  a;
    logic [31:0] d;
    assign done_w = apb_rsp.pready && apb_req.pwrite;
    assign done_r = apb_rsp.pready && !apb_req.pwrite;
    assign a = apb_req.paddr;
    assign d = apb_req.pwdata;
    AST_PIN_FOLLOWS: assert property ($past(arst_n) |-> lock_pin == $past(lock_raw))
        else $error("lock pin does not follow lock detect");
    AST_LIVE_BIT: assert property ($stable(lock_raw) [*4] ##0 (done_r && a == OFS_STATUS)
        |-> apb_rsp.prdata[ST_LIVE] == lock_raw) else $error("live lock bit wrong");
    AST_STICKY_SET: assert property (!lock_raw ##3 (done_r && a == OFS_STATUS)
        |-> apb_rsp.prdata[ST_STICKY]) else $error("sticky bit missed a loss of lock");
    AST_DOUBLER: assert property ($past(arst_n) && $stable(reference_divide_value)
        |-> ref_doubler_en == (reference_divide_value == 8'h00)) else $error("doubler mismatch");
    AST_REFDIV: assert property (done_w && a == OFS_REFDIV
        |-> ##2 reference_divide_value == $past(d[7:0], 2)) else $error("divider not taken");
    AST_WIN: assert property (done_w && a == OFS_LOCKWIN
        |-> ##2 lock_win == $past(d[2:0], 2)) else $error("window not taken");
    AST_SSC_OFF: assert property (done_w && a == OFS_SSC && !d[SSC_EN_BIT]
        |-> ##3 !mod_active) else $error("modulation while spread disabled");
    AST_FORBID: assert property (done_w && a == OFS_SSC && d[SSC_SEL_LO +: 3] > SSC_MAX_SEL
        |-> ##3 !mod_active) else $error("modulation with forbidden profile");
    AST_DIVOUT: assert property (done_r && a == OFS_DIVOUT && $stable(fb_div)
        |-> apb_rsp.prdata[DIVW-1:0] == fb_div) else $error("division readback wrong");
endmodule // fnpll_ctrl_props

bind fnpll_ctrl fnpll_ctrl_props #(.DIVW(DIVW)) u_props (.clk(clk), .arst_n(arst_n), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .lock_raw(lock_raw), .lock_pin(lock_pin), .ref_doubler_en(ref_doubler_en),
    .reference_divide_value(reference_divide_value), .fb_div(fb_div), .se_pfd(se_pfd),
    .lock_win(lock_win), .mod_active(mod_active));

// >>> dv/fnpll_ctrl_tb_top.sv
// self-checking bench for the pll control block
// assumes the lock source model and the bound port checker
module fnpll_ctrl_tb_top
    import fnpll_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic           clk = 1'b0;
    logic           arst_n = 1'b0;
    logic           drop = 1'b0;
    fnpll_apb_req_t req = '0;
    fnpll_apb_rsp_t rsp;
    logic           lock_raw, lock_pin, dbl, se, mact, err;
    logic [7:0]     rdv;
    logic [17:0]    fb;
    logic [2:0]     win;
    logic [31:0]    rd;
    int             fails = 0;
    int             n_compared = 0;
    always #50 clk = ~clk;
    fnpll_ctrl #(.DIVW(18)) dut (.clk(clk), .arst_n(arst_n), .apb_req(req), .apb_rsp(rsp), .lock_raw(lock_raw),
        .lock_pin(lock_pin), .ref_doubler_en(dbl), .reference_divide_value(rdv), .fb_div(fb), .se_pfd(se),
        .lock_win(win), .mod_active(mact));
    fnpll_lock_src #(.SETTLE(20)) u_lock (.clk(clk), .arst_n(arst_n), .drop(drop), .lock_raw(lock_raw));
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int i;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge clk);
        req.penable <= 1'b1;
        i = 0;
        // look between edges so the registered answer has settled
        @(negedge clk);
        while (rsp.pready !== 1'b1 && i < 20) begin
            @(negedge clk);
            i++;
        end
        if (i >= 20) begin
            fails++;
            give_verdict();
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        @(posedge clk);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic t_reset();
        rdc(OFS_REFDIV, 32'h1);
        rdc(OFS_NINT, 32'h60);
        rdc(OFS_DIVOUT, 32'h60);
        apb(1'b1, OFS_DIVOUT, 32'h5);
        rdc(OFS_DIVOUT, 32'h60);
        apb(1'b0, 8'h40, 32'h0);
        chk(err, 1);
        $display("test reset done");
    endtask
    task automatic t_refdiv();
        apb(1'b1, OFS_REFDIV, 32'h0);
        settle();
        chk(dbl, 1);
        apb(1'b1, OFS_REFDIV, 32'hff);
        settle();
        chk(rdv, 8'hff);
        chk(dbl, 0);
        apb(1'b1, OFS_REFDIV, 32'h1);
        $display("test refdiv done");
    endtask
    task automatic t_ratio();
        logic [23:0] nums [2] = '{24'h000001, 24'h800000};
        logic [23:0] dens [2] = '{24'h000002, 24'h000000};
        int sum;
        apb(1'b1, OFS_NINT, 32'h7fff);
        apb(1'b1, OFS_MODE, 32'h0040);
        rdc(OFS_NINT, 32'h7fff);
        rdc(OFS_DIVOUT, 32'h7fff);
        chk(se, 1);
        apb(1'b1, OFS_NINT, 32'ha);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, OFS_NUM, nums[k]);
            apb(1'b1, OFS_DEN, dens[k]);
            rdc(OFS_NUM, nums[k]);
            apb(1'b1, OFS_MODE, 32'h0401);
            sum = 0;
            repeat (200) begin
                @(negedge clk);
                sum += fb - 18'd10;
            end
            chk(sum >= 99 && sum <= 101, 1);
        end
        chk(se, 0);
        $display("test ratio done");
    endtask
    task automatic t_ssc();
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, OFS_SSC, 32'h8000 | (c[3] << 5) | (c[2:0] << 1));
            settle();
            chk(mact, c[2:0] <= 3'h3);
        end
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd[ST_BADSEL], 1);
        apb(1'b1, OFS_SSC, 32'h0022);
        settle();
        chk(mact, 0);
        apb(1'b1, OFS_LOCKWIN, {29'h0, WIN_WIDE});
        settle();
        chk(win, WIN_WIDE);
        $display("test spread done");
    endtask
    task automatic t_lock();
        apb(1'b1, OFS_STATUS, 32'h2);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd[1:0], 2'b01);
        @(posedge clk);
        drop <= 1'b1;
        @(posedge clk);
        drop <= 1'b0;
        repeat (2) @(negedge clk);
        chk(lock_pin, 0);
        settle();
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd[1:0], 2'b11);
        apb(1'b1, OFS_STATUS, 32'h2);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd[1:0], 2'b01);
        $display("test lock done");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_refdiv();
        t_ratio();
        t_ssc();
        t_lock();
        give_verdict();
    end
endmodule // fnpll_ctrl_tb_top
